// [mts_sequencer.sv]
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
module mts_sequencer #(
   parameter int ADDR_W  = 13,
   parameter int DATA_W  = 16,
   parameter int NANO_W  = 9
) (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic [4:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic      [31:0]        avs_readdata,
   output logic                    avs_waitrequest,
   input  wire logic [DATA_W-1:0]  microcode_store,
   input  wire logic [DATA_W-1:0]  memory_info_reg,
   input  wire logic [13:0]        microcode_next_address,
   input  wire logic               nano_parity_bit,
   input  wire logic               nano_parity_err,
   input  wire logic               micro_parity_err,
   input  wire logic               proc_wait,
   output logic      [ADDR_W-1:0]  store_addr,
   output logic      [DATA_W-1:0]  store_wdata,
   output logic                    store_we,
   output logic      [NANO_W-1:0]  nanocode_addr,
   output logic                    nanocode_rd,
   output logic                    clear_processor,
   output logic                    microcode_pc_step,
   output logic                    microcode_pc_clear,
   output logic                    sys_clk_en,
   output logic                    forced_irq_n,
   output logic                    forced_external_n,
   output logic      [DATA_W-1:0]  lamps,
   output logic      [3:0]         step_lamps,
   output logic                    error_lamp,
   output logic                    stop_lamp,
   output logic                    wait_lamp
);
   import mts_pkg::*;

   // Lamp digits and the address range are fixed by the panel
   if (DATA_W != 16) begin : g_chk_data
      $error("mts_sequencer: DATA_W must be 16");
   end
   if (ADDR_W != 13) begin : g_chk_addr
      $error("mts_sequencer: ADDR_W must be 13");
   end
   if (NANO_W < 1 || NANO_W > 16) begin : g_chk_nano
      $error("mts_sequencer: NANO_W out of range");
   end

   logic [CTRL_W-1:0] ctrl;         // Switch settings
   logic              wait_ack;     // Bus answer phase
   logic              force_cmd;    // Button pulses
   logic              single_cmd;
   logic              resume_cmd;
   logic              clrerr_cmd;
   logic [3:0]        step_counter; // Sequence step
   mts_phase_type     phase;        // Phase flip-flop
   logic              error_ff;
   logic              stop_ff;
   logic [DATA_W-1:0] test_address_counter;
   logic [NANO_W-1:0] nano_idx;     // Next nanocode word
   logic              last_flag;    // Range end seen
   logic              cmp_en;       // Read check pending
   logic [DATA_W-1:0] exp_data;     // Expected read data

   // Switch decode
   logic       test_routine_mode;
   logic       loop_step;
   logic       halt_on_mismatch;
   logic       size_8k;
   logic       single_sw;
   logic [1:0] line_force_switch;
   assign test_routine_mode = ctrl[CTRL_MODE];
   assign loop_step         = ctrl[CTRL_LOOP];
   assign halt_on_mismatch  = ctrl[CTRL_HALT];
   assign size_8k           = ctrl[CTRL_SIZE8K];
   assign single_sw         = ctrl[CTRL_SINGLE];
   assign line_force_switch = ctrl[CTRL_LINE +: 2];

   // Bus handshake terms
   logic acc_wr;
   logic acc_rd;
   assign acc_wr = avs_write & ~avs_waitrequest;
   assign acc_rd = avs_read & ~avs_waitrequest;

   // Sequencer timing terms
   logic tick;       // Store test may advance this clock
   logic phase_one;
   logic phase_two;
   logic rw_step;    // Steps 1 to 6 walk the store
   logic wr_step;
   logic rd_step;
   logic step_done;
   logic mismatch;
   logic [ADDR_W-1:0] last_addr;
   logic [ADDR_W-1:0] cur_addr;
   logic [DATA_W-1:0] pattern;
   logic [3:0]        sc_next;

   // The phase only runs in store test, with the clock let through
   assign tick = ~test_routine_mode & ~stop_ff & sys_clk_en;
   assign phase_one = tick & (phase == PH_ONE);
   assign phase_two = tick & (phase == PH_TWO);
   assign rw_step = (step_counter >= SC_WR1) &&
                    (step_counter <= SC_RD3);
   // Odd steps 1, 3, 5 write; even 2, 4, 6 read back
   assign wr_step = rw_step & step_counter[0];
   assign rd_step = rw_step & ~step_counter[0];
   assign cur_addr = test_address_counter[ADDR_W-1:0];
   assign last_addr = size_8k ? LAST_8K : LAST_4K;
   assign mismatch = cmp_en & (microcode_store != exp_data);

   // Pattern generator: worst case, complement or address
   always_comb begin
      logic hi;
      hi = size_8k ? cur_addr[HALF_BIT_8K] : cur_addr[HALF_BIT_4K];
      if (step_counter == SC_WR3 || step_counter == SC_RD3) begin
         pattern = DATA_W'(cur_addr);
      end else if (step_counter == SC_WR2 ||
                   step_counter == SC_RD2) begin
         // Complement of pattern one
         pattern = {DATA_W{~(cur_addr[0] ^ hi)}};
      end else begin
         // Low half: even zeros, odd ones; upper half swapped
         pattern = {DATA_W{cur_addr[0] ^ hi}};
      end
   end

   // Store and parity steps finish once their whole range is covered; steps 0, 7 and 9 finish at once
   always_comb begin
      unique case (step_counter)
         SC_CLEAR0, SC_CLEAR7: step_done = 1'b1;
         SC_PARITY: step_done = last_flag;
         SC_WRAP: step_done = 1'b1;
         default: step_done = rw_step ? last_flag : 1'b1;
      endcase
   end

   // Next step count; step 9 and illegal codes go to 0
   assign sc_next = (step_counter >= SC_WRAP) ? SC_CLEAR0 :
                    4'(step_counter + 4'h1);

   // Avalon answer: one wait cycle, then a one-cycle accept
   always_ff @(posedge clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         wait_ack <= 1'b0;
      end else begin
         // Drop waitrequest for one cycle per request
         wait_ack <= (avs_read | avs_write) & ~wait_ack;
         avs_waitrequest <= ~((avs_read | avs_write) & ~wait_ack);
      end
   end

   // Read data, settled in the cycle the master samples it
   always_ff @(posedge clk) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read & avs_waitrequest & ~wait_ack) begin
         unique case (avs_address)
            OFS_CTRL: avs_readdata <= 32'(ctrl);
            OFS_STATUS: begin
               avs_readdata <= 32'h0000_0000;
               avs_readdata[ST_STEP +: 4] <= step_counter;
               avs_readdata[ST_ERROR] <= error_ff;
               avs_readdata[ST_STOP] <= stop_ff;
               avs_readdata[ST_WAIT] <= wait_lamp;
               avs_readdata[ST_PHASE] <= (phase == PH_TWO);
            end
            OFS_COUNT: avs_readdata <= 32'(test_address_counter);
            OFS_LAMPS: avs_readdata <= 32'(lamps);
            // Command register and holes read as zero
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // Switch register; each byte lane written on its enable
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= CTRL_RESET;
      end else if (acc_wr && avs_address == OFS_CTRL) begin
         if (avs_byteenable[0]) begin
            ctrl[7:0] <= avs_writedata[7:0];
         end
         if (avs_byteenable[1]) begin
            ctrl[8] <= avs_writedata[8];
         end
      end
   end

   // Pushbuttons: one pulse per accepted write of a one
   always_ff @(posedge clk) begin
      if (rst) begin
         force_cmd  <= 1'b0;
         single_cmd <= 1'b0;
         resume_cmd <= 1'b0;
         clrerr_cmd <= 1'b0;
      end else begin
         logic hit;
         hit = acc_wr && avs_address == OFS_CMD && avs_byteenable[0];
         force_cmd  <= hit & avs_writedata[CMD_FORCE];
         single_cmd <= hit & avs_writedata[CMD_SINGLE];
         resume_cmd <= hit & avs_writedata[CMD_RESUME];
         clrerr_cmd <= hit & avs_writedata[CMD_CLRERR];
      end
   end

   // System clock gate: free run, or one pulse per press
   always_ff @(posedge clk) begin
      if (rst) begin
         sys_clk_en <= 1'b0;
      end else if (single_sw) begin
         sys_clk_en <= single_cmd & ~stop_ff;
      end else begin
         sys_clk_en <= ~stop_ff;
      end
   end

   // Phase flip-flop, inhibited by stop or routine mode
   always_ff @(posedge clk) begin
      if (rst) begin
         phase <= PH_ONE;
      end else if (test_routine_mode) begin
         phase <= PH_ONE;
      end else if (tick) begin
         unique case (phase)
            PH_ONE: phase <= PH_TWO;
            PH_TWO: phase <= PH_ONE;
         endcase
      end
   end

   // Step counter: phase two steps it, resume with loop too
   always_ff @(posedge clk) begin
      if (rst) begin
         step_counter <= SC_CLEAR0;
      end else if (resume_cmd & loop_step) begin
         step_counter <= sc_next;
      end else if (phase_two & step_done) begin
         if (loop_step & rw_step) begin
            step_counter <= step_counter;
         end else begin
            step_counter <= sc_next;
         end
      end
   end

   // Address, parity and clock counter
   always_ff @(posedge clk) begin
      if (rst) begin
         test_address_counter <= '0;
      end else if (test_routine_mode) begin
         // Counts clocks between waits; clear-error zeroes it
         if (clrerr_cmd) begin
            test_address_counter <= '0;
         end else if (sys_clk_en & ~proc_wait) begin
            test_address_counter <= test_address_counter + 1'b1;
         end
      end else if (phase_one & rw_step & ~last_flag) begin
         // Stop on the last address so the check sees it
         if (cur_addr != last_addr) begin
            test_address_counter <= test_address_counter + 1'b1;
         end
      end else if (phase_two) begin
         if (step_counter == SC_PARITY) begin
            if (nano_parity_bit) begin
               test_address_counter <=
                  test_address_counter + 1'b1;
            end
         end else if (step_done) begin
            test_address_counter <= '0;
         end
      end
   end

   // Range end flag, taken with the address it belongs to
   always_ff @(posedge clk) begin
      if (rst) begin
         last_flag <= 1'b0;
      end else if (phase_two & step_done) begin
         last_flag <= 1'b0;
      end else if (phase_one & rw_step) begin
         last_flag <= (cur_addr == last_addr);
      end else if (phase_one && step_counter == SC_PARITY) begin
         last_flag <= (nano_idx == {NANO_W{1'b1}});
      end
   end

   // Nanocode walk for the parity tally
   always_ff @(posedge clk) begin
      if (rst) begin
         nano_idx <= '0;
         nanocode_addr <= '0;
         nanocode_rd <= 1'b0;
      end else begin
         nanocode_rd <= 1'b0;
         if (phase_one && step_counter == SC_PARITY) begin
            nanocode_addr <= nano_idx;
            nanocode_rd <= 1'b1;
            nano_idx <= nano_idx + 1'b1;
         end else if (step_counter != SC_PARITY) begin
            nano_idx <= '0;
         end
      end
   end

   // Store port: write in phase one of steps 1, 3, 5
   always_ff @(posedge clk) begin
      if (rst) begin
         store_addr <= '0;
         store_wdata <= '0;
         store_we <= 1'b0;
         cmp_en <= 1'b0;
         exp_data <= '0;
      end else begin
         store_we <= 1'b0;
         if (phase_one & rw_step & ~last_flag) begin
            store_addr <= cur_addr;
            store_wdata <= pattern;
            store_we <= wr_step;
            exp_data <= pattern;
            cmp_en <= rd_step;
         end else if (phase_two) begin
            cmp_en <= 1'b0;
         end
      end
   end

   // Error flip-flop; a new error wins over clear-error
   always_ff @(posedge clk) begin
      if (rst) begin
         error_ff <= 1'b0;
      end else if (test_routine_mode) begin
         error_ff <= 1'b0;
      end else if ((phase_two & rd_step & mismatch) |
                   nano_parity_err | micro_parity_err) begin
         error_ff <= 1'b1;
      end else if (clrerr_cmd) begin
         error_ff <= 1'b0;
      end
   end

   // Stop flip-flop; set wins over resume in the same clock
   always_ff @(posedge clk) begin
      if (rst) begin
         stop_ff <= 1'b0;
      end else if (test_routine_mode) begin
         stop_ff <= 1'b0;
      end else if (halt_on_mismatch &
                   ((phase_two & rd_step & mismatch) |
                    nano_parity_err | micro_parity_err)) begin
         stop_ff <= 1'b1;
      end else if (phase_two && step_counter == SC_PARITY &&
                   step_done && line_force_switch == LINE_IRQ) begin
         stop_ff <= 1'b1;
      end else if (resume_cmd) begin
         stop_ff <= 1'b0;
      end
   end

   // Processor and microcode counter pulses
   always_ff @(posedge clk) begin
      if (rst) begin
         clear_processor <= 1'b0;
         microcode_pc_clear <= 1'b0;
         microcode_pc_step <= 1'b0;
      end else begin
         clear_processor <= phase_two & (step_counter == SC_CLEAR0 ||
                            step_counter == SC_CLEAR7);
         microcode_pc_clear <= phase_two &
                               (step_counter == SC_CLEAR0 ||
                                step_counter == SC_CLEAR7);
         // Button step is meant for the wait lamp in routine mode
         microcode_pc_step <= force_cmd |
                              (phase_two & rw_step &
                               ~step_done);
      end
   end

   // Operator lamps and forced lines
   always_ff @(posedge clk) begin
      if (rst) begin
         lamps <= '0;
         step_lamps <= SC_CLEAR0;
         error_lamp <= 1'b0;
         stop_lamp <= 1'b0;
         wait_lamp <= 1'b0;
         forced_irq_n <= 1'b1;
         forced_external_n <= 1'b1;
      end else begin
         // Digit A is bits 15:12, digit D bits 3:0
         unique case ({ctrl[CTRL_SEL1], ctrl[CTRL_SEL0]})
            2'h0: lamps <= test_address_counter;
            2'h1: lamps <= memory_info_reg;
            2'h2: lamps <= DATA_W'(microcode_next_address);
            2'h3: lamps <= microcode_store;
         endcase
         step_lamps <= step_counter;
         error_lamp <= error_ff;
         stop_lamp <= stop_ff;
         wait_lamp <= test_routine_mode & proc_wait;
         forced_irq_n <= ~(line_force_switch == LINE_IRQ);
         forced_external_n <=
            ~(line_force_switch == LINE_EXT);
      end
   end

endmodule

// [mts_pkg.sv]
package mts_pkg;

   // Register byte offsets
   localparam logic [4:0] OFS_CTRL   = 5'h00;
   localparam logic [4:0] OFS_CMD    = 5'h04;
   localparam logic [4:0] OFS_STATUS = 5'h08;
   localparam logic [4:0] OFS_COUNT  = 5'h0c;
   localparam logic [4:0] OFS_LAMPS  = 5'h10;

   // Control register fields (switch settings)
   localparam int CTRL_MODE   = 0;
   localparam int CTRL_LOOP   = 1;
   localparam int CTRL_HALT   = 2;
   localparam int CTRL_SIZE8K = 3;
   localparam int CTRL_SEL0   = 4;
   localparam int CTRL_SEL1   = 5;
   localparam int CTRL_SINGLE = 6;
   localparam int CTRL_LINE   = 7;
   localparam int CTRL_W      = 9;
   localparam logic [8:0] CTRL_RESET = 9'h000;

   // Command register bits (pushbuttons, write one)
   localparam int CMD_FORCE  = 0;
   localparam int CMD_SINGLE = 1;
   localparam int CMD_RESUME = 2;
   localparam int CMD_CLRERR = 3;

   // Status register fields
   localparam int ST_STEP  = 0;
   localparam int ST_ERROR = 4;
   localparam int ST_STOP  = 5;
   localparam int ST_WAIT  = 6;
   localparam int ST_PHASE = 7;

   // Line switch positions
   localparam logic [1:0] LINE_OFF = 2'h0;
   localparam logic [1:0] LINE_IRQ = 2'h1;
   localparam logic [1:0] LINE_EXT = 2'h2;

   // Step counter codes
   localparam logic [3:0] SC_CLEAR0 = 4'h0;
   localparam logic [3:0] SC_WR1    = 4'h1;
   localparam logic [3:0] SC_RD1    = 4'h2;
   localparam logic [3:0] SC_WR2    = 4'h3;
   localparam logic [3:0] SC_RD2    = 4'h4;
   localparam logic [3:0] SC_WR3    = 4'h5;
   localparam logic [3:0] SC_RD3    = 4'h6;
   localparam logic [3:0] SC_CLEAR7 = 4'h7;
   localparam logic [3:0] SC_PARITY = 4'h8;
   localparam logic [3:0] SC_WRAP   = 4'h9;

   // Store range limits and pattern split bits
   localparam logic [12:0] LAST_8K = 13'h1fff;
   localparam logic [12:0] LAST_4K = 13'h0fff;
   localparam int HALF_BIT_8K = 12;
   localparam int HALF_BIT_4K = 11;

   // Sequencing phase
   typedef enum logic {
      PH_ONE,
      PH_TWO
   } mts_phase_type;

endpackage

// [mts_sequencer_props.sv]
`timescale 1ns/100ps
module mts_sequencer_props (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       store_we,
   input wire logic       nanocode_rd,
   input wire logic       clear_processor,
   input wire logic       microcode_pc_step,
   input wire logic       sys_clk_en,
   input wire logic       forced_irq_n,
   input wire logic       forced_external_n,
   input wire logic [3:0] step_lamps,
   input wire logic       stop_lamp,
   input wire logic       error_lamp
);
   // One clock domain, so clock and reset are given once
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // Store writes belong to the three write steps only
   property p_we_step;
      store_we |-> step_lamps inside {4'h1, 4'h3, 4'h5};
   endproperty
   a_we_step: assert property (p_we_step)
      else $error("store write outside a write step");

   // One address per phase pair, so writes never come back to back
   property p_we_gap;
      store_we |=> !store_we;
   endproperty
   a_we_gap: assert property (p_we_gap)
      else $error("store writes on adjacent cycles");

   // A settled stop keeps the system clock gated off
   property p_stop_clk;
      stop_lamp && $past(stop_lamp) |-> !sys_clk_en;
   endproperty
   a_stop_clk: assert property (p_stop_clk)
      else $error("clock enabled while stopped");

   // The line switch has one position at a time
   property p_line;
      !forced_irq_n |-> forced_external_n;
   endproperty
   a_line: assert property (p_line)
      else $error("both forced lines low");

   // Step counter moves by one, and nine wraps to zero
   property p_step_seq;
      $changed(step_lamps) |-> step_lamps == $past(step_lamps) + 4'h1
         || (step_lamps == 4'h0 && $past(step_lamps) == 4'h9);
   endproperty
   a_step_seq: assert property (p_step_seq)
      else $error("step counter jumped");

   // Force step is a single pulse
   property p_pc_pulse;
      microcode_pc_step |=> !microcode_pc_step;
   endproperty
   a_pc_pulse: assert property (p_pc_pulse)
      else $error("program counter stepped twice");

   // Processor clear only comes from the two clearing steps
   property p_clr;
      clear_processor |-> step_lamps inside {4'h0, 4'h7}
         || $past(step_lamps) inside {4'h0, 4'h7};
   endproperty
   a_clr: assert property (p_clr)
      else $error("processor clear outside a clear step");

   // Nanocode reads belong to the parity step
   property p_nano;
      nanocode_rd |-> step_lamps == 4'h8 || $past(step_lamps) == 4'h8;
   endproperty
   a_nano: assert property (p_nano)
      else $error("nanocode read outside the parity step");

   // A stop has a cause: an error or the end of the parity step
   property p_stop_why;
      $rose(stop_lamp) |-> error_lamp || $past(step_lamps) == 4'h8;
   endproperty
   a_stop_why: assert property (p_stop_why)
      else $error("stop without cause");
endmodule

bind mts_sequencer mts_sequencer_props i_props (
   .clk(clk), .rst(rst), .store_we(store_we), .nanocode_rd(nanocode_rd),
   .clear_processor(clear_processor), .microcode_pc_step(microcode_pc_step),
   .sys_clk_en(sys_clk_en), .forced_irq_n(forced_irq_n),
   .forced_external_n(forced_external_n), .step_lamps(step_lamps),
   .stop_lamp(stop_lamp), .error_lamp(error_lamp)
);

// [mts_store_model.sv]
`timescale 1ns/100ps
module mts_store_model #(
   parameter int NANO_W = 4
) (
   input  wire logic              clk,
   input  wire logic [12:0]       store_addr,
   input  wire logic [15:0]       store_wdata,
   input  wire logic              store_we,
   input  wire logic [NANO_W-1:0] nanocode_addr,
   input  wire logic              nanocode_rd,
   input  wire logic              fault_en,
   input  wire logic [12:0]       fault_addr,
   output logic      [15:0]       microcode_store,
   output logic                   nano_parity_bit
);
   logic [15:0] mem [0:8191]; // Microcode store words

   // Marker fill shows which words a test never wrote
   initial begin
      for (int i = 0; i < 8192; i++) begin
         mem[i] = 16'h5a5a;
      end
   end

   // Writes land at the edge; reads stand in-cycle; fault flips a bit
   always @(posedge clk) begin
      if (store_we) begin
         mem[store_addr] <= store_wdata;
      end
   end
   assign microcode_store = mem[store_addr] ^
      ((fault_en && store_addr == fault_addr) ? 16'h0010 : 16'h0000);
   // Idle parity reads high so a count outside a read shows up
   assign nano_parity_bit = nanocode_rd ? ^nanocode_addr : 1'b1;
endmodule

// [memory_test_sequencer_bench.sv]
`timescale 1ns/100ps
module memory_test_sequencer_bench;
   import mts_pkg::*;
   localparam int NW = 4; // Short nanocode range keeps step 8 brief
   logic          clk, rst, avs_read, avs_write, proc_wait, fault_en;
   logic          avs_waitrequest, nano_parity_bit, nano_parity_err;
   logic          micro_parity_err, store_we, nanocode_rd, clear_processor;
   logic          microcode_pc_step, microcode_pc_clear, sys_clk_en;
   logic          forced_irq_n, forced_external_n;
   logic          error_lamp, stop_lamp, wait_lamp;
   logic [3:0]    avs_byteenable, step_lamps;
   logic [4:0]    avs_address;
   logic [12:0]   store_addr, fault_addr;
   logic [13:0]   microcode_next_address;
   logic [15:0]   microcode_store, memory_info_reg, store_wdata, lamps;
   logic [31:0]   avs_readdata, avs_writedata, rd;
   logic [NW-1:0] nanocode_addr;
   int            n_mismatch = 0;
   int            total_checks = 0;
   int            n_pc = 0, n_clk = 0, n_clr = 0;
   int            snap, exp_par;

   mts_sequencer #(.NANO_W(NW)) i_dut (.clk(clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .microcode_store(microcode_store),
      .memory_info_reg(memory_info_reg),
      .microcode_next_address(microcode_next_address),
      .nano_parity_bit(nano_parity_bit), .nano_parity_err(nano_parity_err),
      .micro_parity_err(micro_parity_err), .proc_wait(proc_wait),
      .store_addr(store_addr), .store_wdata(store_wdata),
      .store_we(store_we), .nanocode_addr(nanocode_addr),
      .nanocode_rd(nanocode_rd), .clear_processor(clear_processor),
      .microcode_pc_step(microcode_pc_step),
      .microcode_pc_clear(microcode_pc_clear), .sys_clk_en(sys_clk_en),
      .forced_irq_n(forced_irq_n), .forced_external_n(forced_external_n),
      .lamps(lamps), .step_lamps(step_lamps), .error_lamp(error_lamp),
      .stop_lamp(stop_lamp), .wait_lamp(wait_lamp));

   mts_store_model #(.NANO_W(NW)) i_store (.clk(clk),
      .store_addr(store_addr), .store_wdata(store_wdata),
      .store_we(store_we), .nanocode_addr(nanocode_addr),
      .nanocode_rd(nanocode_rd), .fault_en(fault_en),
      .fault_addr(fault_addr), .microcode_store(microcode_store),
      .nano_parity_bit(nano_parity_bit));

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Counts program counter steps and clears, and enabled system clocks
   always @(posedge clk) begin
      if (microcode_pc_step === 1'b1) n_pc <= n_pc + 1;
      if (microcode_pc_clear === 1'b1) n_clr <= n_clr + 1;
      if (sys_clk_en === 1'b1) n_clk <= n_clk + 1;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask

   // One Avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20) n_mismatch++;
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   // Ends on a falling edge so registered outputs have settled
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic wait_stop(input int lim);
      int n;
      n = 0;
      while (stop_lamp !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
      tick(1);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Cuts a hung run short
   initial begin
      repeat (90000) @(posedge clk);
      n_mismatch++;
      tally_and_finish;
   end

   initial begin
      rst = 1'b1;
      {avs_read, avs_write, proc_wait, fault_en} = 4'h0;
      {nano_parity_err, micro_parity_err} = 2'h0;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      memory_info_reg = 16'hc3a5;
      microcode_next_address = 14'h2b6c;
      fault_addr = 13'h0005;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, OFS_CTRL, 32'h0);
      check(rd, 32'(CTRL_RESET));
      bus(1'b0, 5'h14, 32'h0);
      check(rd, 32'h0);
      // One full pass, line switch at interrupt, 4K range
      bus(1'b1, OFS_CTRL, 32'h080);
      tick(2);
      check(32'(forced_irq_n), 32'h0);
      check(32'(forced_external_n), 32'h1);
      wait_stop(60000);
      check(32'(stop_lamp), 32'h1);
      check(32'(step_lamps), 32'(SC_WRAP));
      check(n_clr, 32'd2);
      check(32'(error_lamp), 32'h0);
      check(32'(sys_clk_en), 32'h0);
      check(32'(i_store.mem[1]), 32'h1);
      check(32'(i_store.mem[4095]), 32'hfff);
      check(32'(i_store.mem[4096]), 32'h5a5a);
      exp_par = 0;
      for (int a = 0; a < 2 ** NW; a++) exp_par += 32'(^a[NW-1:0]);
      check(32'(lamps), exp_par);
      // The other three lamp sources in turn
      for (int s = 1; s < 4; s++) begin
         bus(1'b1, OFS_CTRL, 32'h080 | 32'(s << 4));
         tick(2);
         check(32'(lamps), s == 1 ? memory_info_reg : s == 2 ?
            {2'b00, microcode_next_address} : microcode_store);
      end
      // Corrupt word 5 and halt on the mismatch
      @(posedge clk);
      fault_en <= 1'b1;
      bus(1'b1, OFS_CTRL, 32'h084);
      bus(1'b1, OFS_CMD, 32'h4);
      tick(3);
      check(32'(stop_lamp), 32'h0);
      wait_stop(20000);
      check(32'(stop_lamp), 32'h1);
      check(32'(error_lamp), 32'h1);
      check(32'(step_lamps), 32'(SC_RD1));
      // Loop mode: resume steps once, then the step recycles
      bus(1'b1, OFS_CTRL, 32'h082);
      bus(1'b1, OFS_CMD, 32'h4);
      tick(3);
      check(32'(step_lamps), 32'(SC_WR2));
      check(32'(stop_lamp), 32'h0);
      tick(10000);
      check(32'(step_lamps), 32'(SC_WR2));
      // Each parity error sets the error flag
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, OFS_CMD, 32'h8);
         tick(2);
         check(32'(error_lamp), 32'h0);
         @(posedge clk);
         nano_parity_err <= (i == 0);
         micro_parity_err <= (i == 1);
         @(posedge clk);
         {nano_parity_err, micro_parity_err} <= 2'h0;
         tick(2);
         check(32'(error_lamp), 32'h1);
      end
      // Routine mode clears the flags, external line forced
      bus(1'b1, OFS_CTRL, 32'h101);
      tick(2);
      check(32'(error_lamp), 32'h0);
      check(32'(forced_external_n), 32'h0);
      check(32'(forced_irq_n), 32'h1);
      @(posedge clk);
      proc_wait <= 1'b1;
      tick(2);
      check(32'(wait_lamp), 32'h1);
      @(posedge clk);
      proc_wait <= 1'b0;
      tick(2);
      check(32'(wait_lamp), 32'h0);
      snap = n_clk;
      tick(10);
      check(n_clk - snap, 32'd10);
      snap = n_pc;
      bus(1'b1, OFS_CMD, 32'h1);
      tick(4);
      check(n_pc - snap, 32'd1);
      bus(1'b1, OFS_CTRL, 32'h041);
      tick(3);
      snap = n_clk;
      bus(1'b1, OFS_CMD, 32'h2);
      tick(4);
      check(n_clk - snap, 32'd1);
      bus(1'b1, OFS_CMD, 32'h8);
      tick(2);
      bus(1'b0, OFS_COUNT, 32'h0);
      check(rd, 32'h0);
      tally_and_finish;
   end
endmodule
